// >>> srb_pkg.sv
// Overview of operation
// - Host word bits 16, 12, 1 reset emulator, configuration, UART when set and the block sleeps.
// - Controller word bits 31, 30 reset short timers, bit 29 misc registers.
// - Controller word bits 20..26 cover pulse generators one to seven, bit 4 zero.
// - Controller word bits 11,10,9,7,6,5,2,1,0 cover the other listed blocks.
// - Second word bits 22..16 cover timers, board links and blink drivers.
// - Second word bits 15..13, 11, 10, 6, 5, 3 cover the remaining blocks.
// - Second word bit 9 commands the quad flash master to sleep.
// - Blocks held in sleep reset may drop writes; wake them before writing.
package srb_pkg;

    localparam int          SRB_AW = 8;
    localparam int          SRB_DW = 32;

    // Register offsets
    localparam logic [7:0]  SRB_OFS_HOST_EN  = 8'h3C;
    localparam logic [7:0]  SRB_OFS_CTL_EN   = 8'h40;
    localparam logic [7:0]  SRB_OFS_CTL2_EN  = 8'h44;
    localparam logic [7:0]  SRB_OFS_HOST_ACT = 8'h50;
    localparam logic [7:0]  SRB_OFS_CTL_ACT  = 8'h54;
    localparam logic [7:0]  SRB_OFS_CTL2_ACT = 8'h58;

    // Reset values
    localparam logic [31:0] SRB_RST_HOST_EN  = 32'h0000_0000;
    localparam logic [31:0] SRB_RST_CTL_EN   = 32'h0000_0000;
    localparam logic [31:0] SRB_RST_CTL2_EN  = 32'h0000_0000;

    // Host word field positions
    localparam int SRB_B_KEYBOARD_EMULATOR      = 16;
    localparam int SRB_B_GLOBAL_CONFIGURATION   = 12;
    localparam int SRB_B_UART_ZERO              = 1;

    // Controller word field positions
    localparam int SRB_B_SECOND_SHORT_TIMER     = 31;
    localparam int SRB_B_FIRST_SHORT_TIMER      = 30;
    localparam int SRB_B_CONTROLLER_MISC_REGS   = 29;
    localparam int SRB_B_PULSE_GEN_ONE          = 20;
    localparam int SRB_N_PULSE_GEN_HIGH         = 7;
    localparam int SRB_B_FAN_SPEED_MONITOR_ONE  = 11;
    localparam int SRB_B_TWO_WIRE_ZERO          = 10;
    localparam int SRB_B_WATCHDOG_UNIT          = 9;
    localparam int SRB_B_TRACE_PORT             = 7;
    localparam int SRB_B_DMA                    = 6;
    localparam int SRB_B_POWER_MGMT_INTERFACE   = 5;
    localparam int SRB_B_PULSE_GEN_ZERO         = 4;
    localparam int SRB_B_FAN_SPEED_MONITOR_ZERO = 2;
    localparam int SRB_B_THERMAL_BUS_INTERFACE  = 1;
    localparam int SRB_B_INTERRUPT_AGGREGATOR   = 0;

    // Second controller word field positions
    localparam int SRB_B_FOURTH_SHORT_TIMER     = 22;
    localparam int SRB_B_THIRD_SHORT_TIMER      = 21;
    localparam int SRB_B_BOARD_LINK_ONE         = 20;
    localparam int SRB_B_BOARD_LINK_ZERO        = 19;
    localparam int SRB_B_BLINK_DRIVER_ZERO      = 16;
    localparam int SRB_N_BLINK_DRIVER           = 3;
    localparam int SRB_B_TWO_WIRE_ONE           = 13;
    localparam int SRB_N_TWO_WIRE_HIGH          = 3;
    localparam int SRB_B_KEY_MATRIX_SCANNER     = 11;
    localparam int SRB_B_HIBERNATION_COUNTER    = 10;
    localparam int SRB_B_FLASH_SLEEP_CMD        = 9;
    localparam int SRB_B_LEGACY_POINTER_ONE     = 6;
    localparam int SRB_B_LEGACY_POINTER_ZERO    = 5;
    localparam int SRB_B_CONVERTER              = 3;

    // Writable bits of each word
    localparam logic [31:0] SRB_WMASK_HOST = 32'h0001_1002;
    localparam logic [31:0] SRB_WMASK_CTL  = 32'hE7F0_0EF7;
    localparam logic [31:0] SRB_WMASK_CTL2 = 32'h007F_EE68;
    // Bits of each word that qualify a block reset
    localparam logic [31:0] SRB_QMASK_HOST = SRB_WMASK_HOST;
    localparam logic [31:0] SRB_QMASK_CTL  = SRB_WMASK_CTL;
    localparam logic [31:0] SRB_QMASK_CTL2 = 32'h007F_EC68;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [SRB_AW-1:0] addr;
        logic [SRB_DW-1:0] wdata;
    } srb_bus_req_s;

    typedef enum logic [2:0] {
        SRB_SEL_NONE,
        SRB_SEL_HOST_EN,
        SRB_SEL_CTL_EN,
        SRB_SEL_CTL2_EN,
        SRB_SEL_HOST_ACT,
        SRB_SEL_CTL_ACT,
        SRB_SEL_CTL2_ACT
    } srb_sel_e;

endpackage : srb_pkg

// >>> srb_sleep_qual.sv
`timescale 1ns/1ps
`default_nettype none
module srb_sleep_qual
    import srb_pkg::*;
#(
    parameter int          W    = 32,
    parameter logic [W-1:0] MASK = '1
) (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_arst_n,
    // Enables and sleep states
    input  wire logic [W-1:0] i_enable,
    input  wire logic [W-1:0] i_sleep,
    // Per-block reset, high = held in reset
    output logic      [W-1:0] o_block_rst
);

    // Refused at elaboration, before any logic is built
    if (W < 1 || W > SRB_DW) begin : g_bad_width
        $error("srb_sleep_qual: width out of range");
    end

    // System reset holds every qualified block in reset
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_block_rst <= MASK;
        end else begin
            o_block_rst <= MASK & i_enable & i_sleep;
        end
    end

endmodule : srb_sleep_qual
`default_nettype wire

// >>> srb_sleep_reset_bank.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module srb_sleep_reset_bank
    import srb_pkg::*;
(
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_arst_n,
    // Register port
    input  wire srb_bus_req_s      i_bus,
    output logic      [SRB_DW-1:0] o_rdata,
    // Sleep state of each block, per enable bit
    input  wire logic [31:0]       i_host_sleep,
    input  wire logic [31:0]       i_ctl_sleep,
    input  wire logic [31:0]       i_ctl2_sleep,
    // Packed per-block resets, high = in reset
    output logic      [31:0]       o_host_rst,
    output logic      [31:0]       o_ctl_rst,
    output logic      [31:0]       o_ctl2_rst,
    // Host side blocks
    output logic                   o_keyboard_emulator_rst,
    output logic                   o_global_configuration_rst,
    output logic                   o_uart_zero_rst,
    // Controller side timers and registers
    output logic                   o_first_short_timer_rst,
    output logic                   o_second_short_timer_rst,
    output logic                   o_third_short_timer_rst,
    output logic                   o_fourth_short_timer_rst,
    output logic                   o_controller_misc_registers_rst,
    // Pulse generators zero to seven
    output logic      [7:0]        o_pulse_generator_rst,
    // Other controller side blocks
    output logic                   o_fan_speed_monitor_zero_rst,
    output logic                   o_fan_speed_monitor_one_rst,
    output logic                   o_watchdog_unit_rst,
    output logic                   o_trace_port_rst,
    output logic                   o_dma_rst,
    output logic                   o_power_management_interface_rst,
    output logic                   o_thermal_bus_interface_rst,
    output logic                   o_interrupt_aggregator_rst,
    // Second controller word blocks, except two-wire zero from the first word
    output logic      [1:0]        o_board_link_rst,
    output logic      [2:0]        o_blink_driver_rst,
    output logic      [3:0]        o_two_wire_controller_rst,
    output logic                   o_key_matrix_scanner_rst,
    output logic                   o_hibernation_counter_rst,
    output logic      [1:0]        o_legacy_pointer_port_rst,
    output logic                   o_converter_rst,
    // Quad flash master sleep command
    output logic                   o_flash_sleep_cmd
);

    srb_sel_e          sel;
    logic [31:0]       host_en_r;
    logic [31:0]       ctl_en_r;
    logic [31:0]       ctl2_en_r;
    logic [31:0]       host_en_nxt;
    logic [31:0]       ctl_en_nxt;
    logic [31:0]       ctl2_en_nxt;
    logic [31:0]       host_rst_r;
    logic [31:0]       ctl_rst_r;
    logic [31:0]       ctl2_rst_r;
    logic [SRB_DW-1:0] rdata_r;
    logic [SRB_DW-1:0] rdata_nxt;
    logic              flash_sleep_r;

    // Address decode, shared by write and read paths
    function automatic srb_sel_e decode(input logic [SRB_AW-1:0] addr);
        srb_sel_e s;
        s = SRB_SEL_NONE;
        unique case (addr)
            SRB_OFS_HOST_EN:  s = SRB_SEL_HOST_EN;
            SRB_OFS_CTL_EN:   s = SRB_SEL_CTL_EN;
            SRB_OFS_CTL2_EN:  s = SRB_SEL_CTL2_EN;
            SRB_OFS_HOST_ACT: s = SRB_SEL_HOST_ACT;
            SRB_OFS_CTL_ACT:  s = SRB_SEL_CTL_ACT;
            SRB_OFS_CTL2_ACT: s = SRB_SEL_CTL2_ACT;
            default:          s = SRB_SEL_NONE;
        endcase
        return s;
    endfunction : decode

    assign sel = decode(i_bus.addr);

    // Only the writable bits take write data; reserved bits stay zero
    always_comb begin
        host_en_nxt = host_en_r;
        ctl_en_nxt  = ctl_en_r;
        ctl2_en_nxt = ctl2_en_r;
        if (i_bus.wr) begin
            unique case (sel)
                SRB_SEL_HOST_EN: host_en_nxt = i_bus.wdata & SRB_WMASK_HOST;
                SRB_SEL_CTL_EN:  ctl_en_nxt  = i_bus.wdata & SRB_WMASK_CTL;
                SRB_SEL_CTL2_EN: ctl2_en_nxt = i_bus.wdata & SRB_WMASK_CTL2;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            host_en_r <= SRB_RST_HOST_EN;
        end else begin
            host_en_r <= host_en_nxt;
        end
    end

    // Pulse generators, fans, watchdog and the rest share this word
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctl_en_r <= SRB_RST_CTL_EN;
        end else begin
            ctl_en_r <= ctl_en_nxt;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctl2_en_r <= SRB_RST_CTL2_EN;
        end else begin
            ctl2_en_r <= ctl2_en_nxt;
        end
    end

    // Flash master sleeps when it next can; it owns the moment, not us
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flash_sleep_r <= 1'b0;
        end else begin
            flash_sleep_r <= ctl2_en_nxt[SRB_B_FLASH_SLEEP_CMD];
        end
    end

    // Read data stand for exactly one cycle after the strobe
    always_comb begin
        rdata_nxt = '0;
        if (i_bus.rd) begin
            unique case (sel)
                SRB_SEL_HOST_EN:  rdata_nxt = host_en_r;
                SRB_SEL_CTL_EN:   rdata_nxt = ctl_en_r;
                SRB_SEL_CTL2_EN:  rdata_nxt = ctl2_en_r;
                SRB_SEL_HOST_ACT: rdata_nxt = host_rst_r;
                SRB_SEL_CTL_ACT:  rdata_nxt = ctl_rst_r;
                SRB_SEL_CTL2_ACT: rdata_nxt = ctl2_rst_r;
                default:          rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Sleep reset qualifiers; a block in this reset may drop writes
    srb_sleep_qual #(
        .W    (32),
        .MASK (SRB_QMASK_HOST)
    ) u_host_qual (
        .i_core_clk  (i_core_clk),
        .i_arst_n    (i_arst_n),
        .i_enable    (host_en_r),
        .i_sleep     (i_host_sleep),
        .o_block_rst (host_rst_r)
    );

    srb_sleep_qual #(
        .W    (32),
        .MASK (SRB_QMASK_CTL)
    ) u_ctl_qual (
        .i_core_clk  (i_core_clk),
        .i_arst_n    (i_arst_n),
        .i_enable    (ctl_en_r),
        .i_sleep     (i_ctl_sleep),
        .o_block_rst (ctl_rst_r)
    );

    // Flash command bit is left out of the qualifier mask
    srb_sleep_qual #(
        .W    (32),
        .MASK (SRB_QMASK_CTL2)
    ) u_ctl2_qual (
        .i_core_clk  (i_core_clk),
        .i_arst_n    (i_arst_n),
        .i_enable    (ctl2_en_r),
        .i_sleep     (i_ctl2_sleep),
        .o_block_rst (ctl2_rst_r)
    );

    assign o_rdata           = rdata_r;
    assign o_host_rst        = host_rst_r;
    assign o_ctl_rst         = ctl_rst_r;
    assign o_ctl2_rst        = ctl2_rst_r;
    assign o_flash_sleep_cmd = flash_sleep_r;

    // Named views of the qualifier flops
    assign o_keyboard_emulator_rst    = host_rst_r[SRB_B_KEYBOARD_EMULATOR];
    assign o_global_configuration_rst = host_rst_r[SRB_B_GLOBAL_CONFIGURATION];
    assign o_uart_zero_rst            = host_rst_r[SRB_B_UART_ZERO];

    assign o_second_short_timer_rst        = ctl_rst_r[SRB_B_SECOND_SHORT_TIMER];
    assign o_first_short_timer_rst         = ctl_rst_r[SRB_B_FIRST_SHORT_TIMER];
    assign o_controller_misc_registers_rst = ctl_rst_r[SRB_B_CONTROLLER_MISC_REGS];
    assign o_fourth_short_timer_rst        = ctl2_rst_r[SRB_B_FOURTH_SHORT_TIMER];
    assign o_third_short_timer_rst         = ctl2_rst_r[SRB_B_THIRD_SHORT_TIMER];

    assign o_pulse_generator_rst[0] = ctl_rst_r[SRB_B_PULSE_GEN_ZERO];
    generate
        for (genvar g = 0; g < SRB_N_PULSE_GEN_HIGH; g++) begin : g_pulse
            assign o_pulse_generator_rst[g+1] = ctl_rst_r[SRB_B_PULSE_GEN_ONE+g];
        end
    endgenerate

    assign o_fan_speed_monitor_one_rst      = ctl_rst_r[SRB_B_FAN_SPEED_MONITOR_ONE];
    assign o_watchdog_unit_rst              = ctl_rst_r[SRB_B_WATCHDOG_UNIT];
    assign o_trace_port_rst                 = ctl_rst_r[SRB_B_TRACE_PORT];
    assign o_dma_rst                        = ctl_rst_r[SRB_B_DMA];
    assign o_power_management_interface_rst = ctl_rst_r[SRB_B_POWER_MGMT_INTERFACE];
    assign o_fan_speed_monitor_zero_rst     = ctl_rst_r[SRB_B_FAN_SPEED_MONITOR_ZERO];
    assign o_thermal_bus_interface_rst      = ctl_rst_r[SRB_B_THERMAL_BUS_INTERFACE];
    assign o_interrupt_aggregator_rst       = ctl_rst_r[SRB_B_INTERRUPT_AGGREGATOR];

    assign o_board_link_rst[1] = ctl2_rst_r[SRB_B_BOARD_LINK_ONE];
    assign o_board_link_rst[0] = ctl2_rst_r[SRB_B_BOARD_LINK_ZERO];
    generate
        for (genvar g = 0; g < SRB_N_BLINK_DRIVER; g++) begin : g_blink
            assign o_blink_driver_rst[g] = ctl2_rst_r[SRB_B_BLINK_DRIVER_ZERO+g];
        end
    endgenerate

    // Two-wire zero lives in the first controller word
    assign o_two_wire_controller_rst[0] = ctl_rst_r[SRB_B_TWO_WIRE_ZERO];
    generate
        for (genvar g = 0; g < SRB_N_TWO_WIRE_HIGH; g++) begin : g_twowire
            assign o_two_wire_controller_rst[g+1] = ctl2_rst_r[SRB_B_TWO_WIRE_ONE+g];
        end
    endgenerate

    assign o_key_matrix_scanner_rst     = ctl2_rst_r[SRB_B_KEY_MATRIX_SCANNER];
    assign o_hibernation_counter_rst    = ctl2_rst_r[SRB_B_HIBERNATION_COUNTER];
    assign o_legacy_pointer_port_rst[1] = ctl2_rst_r[SRB_B_LEGACY_POINTER_ONE];
    assign o_legacy_pointer_port_rst[0] = ctl2_rst_r[SRB_B_LEGACY_POINTER_ZERO];
    assign o_converter_rst              = ctl2_rst_r[SRB_B_CONVERTER];

endmodule : srb_sleep_reset_bank
`default_nettype wire

// >>> srb_sleep_reset_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none
module srb_sleep_reset_bank_chk
    import srb_pkg::*;
(
    // Clock, reset and register port
    input wire logic              i_core_clk,
    input wire logic              i_arst_n,
    input wire srb_bus_req_s      i_bus,
    input wire logic [SRB_DW-1:0] o_rdata,
    // Sleep states and block resets
    input wire logic [31:0]       i_ctl_sleep,
    input wire logic [31:0]       o_host_rst,
    input wire logic [31:0]       o_ctl_rst,
    input wire logic [31:0]       o_ctl2_rst,
    input wire logic [7:0]        o_pulse_generator_rst,
    input wire logic [3:0]        o_two_wire_controller_rst,
    input wire logic              o_flash_sleep_cmd
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    logic w44;
    assign w44 = i_bus.wr && i_bus.addr == 8'h44;

    a_rdata_idle_zero: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_readback_mask: assert property ((i_bus.wr && i_bus.addr == 8'h40) ##1
        (i_bus.rd && i_bus.addr == 8'h40) |=> o_rdata == ($past(i_bus.wdata, 2) & 32'hE7F0_0EF7))
        else $error("read after write shows wrong bits");
    a_unmapped_zero: assert property (i_bus.rd && !(i_bus.addr inside
        {8'h3C, 8'h40, 8'h44, 8'h50, 8'h54, 8'h58}) |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_flash_cmd_set: assert property (w44 |=> ##1
        o_flash_sleep_cmd == $past(i_bus.wdata[9], 2))
        else $error("flash sleep command does not follow write");
    a_flash_cmd_hold: assert property (!$past(w44) && !$past(w44, 2) |->
        $stable(o_flash_sleep_cmd))
        else $error("flash sleep command moved without write");
    a_reset_needs_sleep: assert property ($past(i_arst_n) |->
        (o_ctl_rst & ~$past(i_ctl_sleep)) == 32'h0)
        else $error("block reset without sleep");
    a_host_reserved: assert property ((o_host_rst & ~32'h0001_1002) == 32'h0)
        else $error("reserved host reset bit set");
    a_ctl2_reserved: assert property ((o_ctl2_rst & ~32'h007F_EC68) == 32'h0)
        else $error("reserved second word reset bit set");
    a_pulse_map: assert property (
        o_pulse_generator_rst == {o_ctl_rst[26:20], o_ctl_rst[4]})
        else $error("pulse generator resets misplaced");
    a_two_wire_map: assert property (
        o_two_wire_controller_rst == {o_ctl2_rst[15:13], o_ctl_rst[10]})
        else $error("two wire resets misplaced");

    c_flash_write: cover property (w44 ##2 o_flash_sleep_cmd);
    c_misc_reset: cover property ($rose(o_ctl_rst[29]));
    c_back_to_back: cover property ((i_bus.wr && i_bus.addr == 8'h40) ##1 i_bus.rd);
endmodule : srb_sleep_reset_bank_chk

bind srb_sleep_reset_bank srb_sleep_reset_bank_chk u_chk (
    .i_core_clk, .i_arst_n, .i_bus, .o_rdata, .i_ctl_sleep, .o_host_rst, .o_ctl_rst,
    .o_ctl2_rst, .o_pulse_generator_rst, .o_two_wire_controller_rst, .o_flash_sleep_cmd
);
`default_nettype wire

// >>> srb_sleep_reset_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end
module srb_sleep_reset_bank_bench
    import srb_pkg::*;
;
    logic         i_core_clk, i_arst_n, kbd, glb, uart, t0, t1, t2, t3, misc, flash;
    logic         fan0, fan1, wdt, trc, dma, pmi, thr, intr, key, hib, conv;
    logic [1:0]   bl, lp;
    logic [2:0]   bd;
    logic [3:0]   tw;
    logic [7:0]   pg;
    logic [31:0]  o_rdata, hs, cs, c2s, hr, cr, c2r;
    srb_bus_req_s i_bus;
    int           mismatches = 0;
    int           num_checks = 0;

    srb_sleep_reset_bank dut (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_bus(i_bus), .o_rdata(o_rdata),
        .i_host_sleep(hs), .i_ctl_sleep(cs), .i_ctl2_sleep(c2s),
        .o_host_rst(hr), .o_ctl_rst(cr), .o_ctl2_rst(c2r),
        .o_keyboard_emulator_rst(kbd), .o_global_configuration_rst(glb),
        .o_uart_zero_rst(uart), .o_first_short_timer_rst(t0), .o_second_short_timer_rst(t1),
        .o_third_short_timer_rst(t2), .o_fourth_short_timer_rst(t3),
        .o_controller_misc_registers_rst(misc), .o_pulse_generator_rst(pg),
        .o_fan_speed_monitor_zero_rst(fan0), .o_fan_speed_monitor_one_rst(fan1),
        .o_watchdog_unit_rst(wdt), .o_trace_port_rst(trc), .o_dma_rst(dma),
        .o_power_management_interface_rst(pmi), .o_thermal_bus_interface_rst(thr),
        .o_interrupt_aggregator_rst(intr), .o_board_link_rst(bl), .o_blink_driver_rst(bd),
        .o_two_wire_controller_rst(tw), .o_key_matrix_scanner_rst(key),
        .o_hibernation_counter_rst(hib), .o_legacy_pointer_port_rst(lp),
        .o_converter_rst(conv), .o_flash_sleep_cmd(flash)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    task automatic finish_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // Request held from one edge to the next; callers chain them back to back
    task automatic bus(input logic w, r, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_bus <= '{wr: w, rd: r, addr: a, wdata: d};
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, 1'b1, a, 32'h0);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        #1;
        `CHK(o_rdata, e)
    endtask : rd_chk

    task automatic wr_all(input logic [31:0] d);
        bus(1'b1, 1'b0, 8'h3C, d);
        bus(1'b1, 1'b0, 8'h40, d);
        bus(1'b1, 1'b0, 8'h44, d);
        bus(1'b0, 1'b0, 8'h00, 32'h0);
        @(posedge i_core_clk);
        #1;
    endtask : wr_all

    task automatic t_reset();
        @(posedge i_core_clk);
        i_arst_n <= 1'b0;
        repeat (10) @(posedge i_core_clk);
        #1;
        `CHK({hr, cr, c2r}, {32'h0001_1002, 32'hE7F0_0EF7, 32'h007F_EC68})
        `CHK({flash, o_rdata}, 33'h0)
        @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        rd_chk(8'h3C, 32'h0);
        rd_chk(8'h40, 32'h0);
        rd_chk(8'h44, 32'h0);
    endtask : t_reset

    // Reserved bits read zero, unmapped space ignored, back-to-back readback
    task automatic t_regs();
        wr_all(32'hFFFF_FFFF);
        rd_chk(8'h3C, 32'h0001_1002);
        rd_chk(8'h44, 32'h007F_EE68);
        bus(1'b1, 1'b0, 8'h48, 32'h0);
        rd_chk(8'h48, 32'h0);
        rd_chk(8'h40, 32'hE7F0_0EF7);
        bus(1'b1, 1'b0, 8'h40, 32'h0F0F_0F0F);
        rd_chk(8'h40, 32'h0700_0E07);
    endtask : t_regs

    // Sleep held high, so each reset follows its enable bit
    task automatic t_map(input logic [31:0] p);
        wr_all(p);
        `CHK({hr, cr, c2r}, {p, p, p} & {32'h0001_1002, 32'hE7F0_0EF7, 32'h007F_EC68})
        `CHK(flash, p[9])
        `CHK({kbd, glb, uart}, {p[16], p[12], p[1]})
        `CHK({t1, t0, misc}, p[31:29])
        `CHK(pg, {p[26:20], p[4]})
        `CHK({fan1, wdt, trc, dma, pmi, fan0, thr, intr}, {p[11], p[9], p[7:5], p[2:0]})
        `CHK({t3, t2, bl, bd}, p[22:16])
        `CHK({tw, key, hib, lp, conv}, {p[15:13], p[10], p[11], p[10], p[6:5], p[3]})
    endtask : t_map

    // Reset only while asleep, one cycle after the sleep change
    task automatic t_sleep();
        wr_all(32'hFFFF_FFFF);
        @(posedge i_core_clk);
        {hs, cs, c2s} <= '0;
        @(posedge i_core_clk);
        cs <= 32'h2000_0001;
        #1;
        `CHK({hr, cr, c2r}, 96'h0)
        @(posedge i_core_clk);
        #1;
        `CHK(cr, 32'h2000_0001)
        `CHK(flash, 1'b1)
        `CHK({hr, c2r}, 64'h0)
        rd_chk(8'h54, 32'h2000_0001);
        rd_chk(8'h50, 32'h0);
        rd_chk(8'h58, 32'h0);
    endtask : t_sleep

    initial begin
        i_arst_n = 1'b0;
        i_bus = '0;
        {hs, cs, c2s} = {96{1'b1}};
        t_reset();
        t_regs();
        t_map(32'h5555_5555);
        t_map(32'hAAAA_AAAA);
        t_map(32'h0);
        t_sleep();
        t_reset();
        finish_test();
    end

    // Whole run is about eighty cycles
    initial begin
        #(100 * 3000);
        mismatches++;
        finish_test();
    end
endmodule : srb_sleep_reset_bank_bench
`default_nettype wire
